// ---- pkg/pbil_pkg.sv ----
// constants shared by the print buffer interlace loader
package pbil_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, 32-bit words)
  // ----------------------------------------------------------------
  localparam logic [3:0] PBIL_CTRL_ADR   = 4'h0;
  localparam logic [3:0] PBIL_STATUS_ADR = 4'h4;
  localparam logic [3:0] PBIL_WRCNT_ADR  = 4'h8;

  // control fields
  localparam int PBIL_CTRL_START_BIT = 0;   // load print instruction
  localparam int PBIL_CTRL_CLRERR_BIT = 1;  // clear buffer error flag
  localparam int PBIL_CTRL_DONE_BIT  = 2;   // printing finished

  // status fields
  localparam int PBIL_ST_LOAD_BIT  = 0;
  localparam int PBIL_ST_PRINT_BIT = 1;
  localparam int PBIL_ST_ERR_BIT   = 2;
  localparam int PBIL_ST_REV_LSB   = 4;   // 2 bits
  localparam int PBIL_ST_QUAD_LSB  = 6;   // 2 bits
  localparam int PBIL_ST_WORD_LSB  = 8;   // 4 bits
  localparam int PBIL_ST_WIN_BIT   = 12;

  // ----------------------------------------------------------------
  // cycling unit phases that qualify sentinels
  // ----------------------------------------------------------------
  localparam logic [3:0] PBIL_T11 = 4'hb;
  localparam logic [3:0] PBIL_T10 = 4'ha;
  localparam logic [3:0] PBIL_T9  = 4'h9;
  localparam logic [3:0] PBIL_T8  = 4'h8;
  localparam logic [3:0] PBIL_T7  = 4'h7;
  localparam logic [3:0] PBIL_T5  = 4'h5;
  localparam logic [3:0] PBIL_T4  = 4'h4;
  localparam logic [3:0] PBIL_T3  = 4'h3;
  localparam logic [3:0] PBIL_T2  = 4'h2;
  localparam logic [3:0] PBIL_T0  = 4'h0;

  // timing band locations of the key sentinels
  localparam logic [7:0] PBIL_LOC_TURN = 8'd198;
  localparam logic [7:0] PBIL_LOC_END  = 8'd187;

  // ----------------------------------------------------------------
  // counts and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] PBIL_GROUP_WORDS = 4'd14;
  localparam logic [1:0] PBIL_REV_LAST    = 2'd3;
  localparam logic [7:0] PBIL_HEADS_WRITE = 8'b0111_1111; // seven heads

  typedef enum logic [1:0] {
    PBIL_IDLE,
    PBIL_LOAD,
    PBIL_PRINT
  } pbil_mode_t;

endpackage

// ---- rtl/pbil_loader.sv ----
// print buffer interlace loader: drum band to print buffer sequencer
// ------------------------------------------------------------------
// Summary of operation
// [R1] fetch sentinel sets main storage read
// [R2] pass one load mark sets register control
// [R3] primed mark steers parts into A or X
// [R4] pass one store trigger writes buffer thrice
// [R5] pass one loads words 1,2,3,8,9
// [R6] turn sentinel at 198 steps revolution
// [R7] write quadrant sentinels step quadrant counter
// [R8] pass two latch start sets register control
// [R9] pass two store mark sets write control
// [R10] pass two writes W3,10,4,11,5,12
// [R11] pass three latch sets register control
// [R12] pass three store trigger sets write control
// [R13] pass three writes W12,6,13,7,14
// [R14] ending sentinel at 187 clears, starts print
// [R15] read quadrant sentinels step quadrant counter
// [R16] group seed sets word counter first stage
// [R17] word counter counts fourteen words
// [R18] error window gates buffer error flag
// [R19] primed part five locations after unprimed
// [R20] A holds four bits, X two bits plus check
// [R21] seven heads write together
// [R22] revolution selects which marks act
// [R23] write flops clear after each write
// ------------------------------------------------------------------
module pbil_loader
  import pbil_pkg::*;
#(
  parameter int CHARS = 10   // characters per word
) (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // wishbone slave
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  input  wire logic               we_i,
  input  wire logic [3:0]         adr_i,
  input  wire logic [3:0]         sel_i,
  input  wire logic [31:0]        dat_i,
  output logic      [31:0]        dat_o,
  output logic                    ack_o,
  // drum timing pins (asynchronous)
  input  wire logic               phase_stb_i,
  input  wire logic [3:0]         phase_i,
  input  wire logic [3:0]         band_ts_i,
  // main storage word part (processor clock domain)
  input  wire logic [CHARS*4-1:0] ms_word_i,
  input  wire logic [CHARS*2-1:0] ms_prime_i,
  input  wire logic [CHARS-1:0]   ms_check_i,
  // comparator status (processor clock domain)
  input  wire logic               cmp_active_i,
  input  wire logic               cmp_error_i,
  // main storage and buffer controls
  output logic                    ms_read_o,
  output logic                    buf_write_o,
  output logic [7:0]              head_en_o,
  output logic [CHARS*4-1:0]      track_a_o,
  output logic [CHARS*3-1:0]      track_x_o,
  output logic [1:0]              quadrant_o,
  output logic                    read_block_o,
  // print hand over
  output logic                    print_start_pulse_o,
  output logic                    print_flag_o,
  output logic                    buf_error_o,
  output logic [3:0]              word_count_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [8:0] sync1_ff;   // first stage, read by second only
  logic [8:0] sync2_ff;   // usable copy
  logic       stb3_ff;    // previous strobe for edge detect

  // drum pins run off the drum; two flops before use
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      stb3_ff  <= 1'b0;
    end else begin
      sync1_ff <= {phase_stb_i, phase_i, band_ts_i};
      sync2_ff <= sync1_ff;
      stb3_ff  <= sync2_ff[8];
    end
  end

  logic       ph_new;    // one pulse per new phase
  logic [3:0] ph;        // current phase number
  logic [3:0] ts;        // timing band tracks 1..4
  assign ph_new = sync2_ff[8] & ~stb3_ff;
  assign ph     = sync2_ff[7:4];
  assign ts     = sync2_ff[3:0];

  // ----------------------------------------------------------------
  // sentinel decode: phase combined with band tracks
  // ----------------------------------------------------------------
  logic s_a, s_b, s_c, s_d, s_e, s_f, s_h, s_i, s_j, s_k, s_y;
  logic s_wq, s_rq, s_end, s_loc;

  always_comb begin
    s_a   = ph_new & (ph == PBIL_T9)  & ts[0];
    s_b   = ph_new & (ph == PBIL_T8)  & ts[1];   // see [R1]
    s_c   = ph_new & (ph == PBIL_T10) & ts[0];
    s_d   = ph_new & (ph == PBIL_T10) & ts[1];
    s_e   = ph_new & (ph == PBIL_T10) & ts[2];
    s_f   = ph_new & (ph == PBIL_T10) & ts[3];
    s_h   = ph_new & (ph == PBIL_T3)  & ts[0];
    s_i   = ph_new & (ph == PBIL_T3)  & ts[1];
    s_j   = ph_new & (ph == PBIL_T3)  & ts[3];
    s_k   = ph_new & (ph == PBIL_T5)  & ts[1];
    s_y   = ph_new & (ph == PBIL_T7)  & ts[0];
    // write_quadrant_step_x/y/z share one decode
    s_wq  = ph_new & (ph == PBIL_T11) & (|ts[3:1]);
    // read_quadrant_step_x/y/z share one decode
    s_rq  = ph_new & (ph == PBIL_T4)  & (|ts[2:0]);
    // composite: t2 with none of tracks 2..4
    s_end = ph_new & (ph == PBIL_T2)  & ~(|ts[3:1]);
    s_loc = ph_new & (ph == PBIL_T0);
  end

  // ----------------------------------------------------------------
  // mode and revolution counter
  // ----------------------------------------------------------------
  pbil_mode_t mode_ff;
  logic [1:0] rev_ff;       // 0 armed, 1..3 loading pass
  logic       start_req;    // software start write
  logic       done_req;     // software ends printing

  // revolution picks the live marks; stale passes ignored
  logic load_mark;          // see [R22]
  logic store_mark;
  always_comb begin
    load_mark  = 1'b0;
    store_mark = 1'b0;
    if (mode_ff == PBIL_LOAD) begin
      unique case (rev_ff)
        2'd1: begin
          load_mark  = s_c;   // see [R2]
          store_mark = s_h;   // see [R4]
        end
        2'd2: begin
          load_mark  = s_d;   // see [R8]
          store_mark = s_i;   // see [R9]
        end
        2'd3: begin
          load_mark  = s_e;   // see [R11]
          store_mark = s_j;   // see [R12]
        end
        default: begin
          load_mark  = 1'b0;  // armed: waiting first turn mark
          store_mark = 1'b0;
        end
      endcase
    end
  end

  // mode sequencing: idle, load three passes, print
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_ff <= PBIL_IDLE;
    end else begin
      unique case (mode_ff)
        PBIL_IDLE: begin
          if (start_req) begin
            mode_ff <= PBIL_LOAD;
          end
        end
        PBIL_LOAD: begin
          if (s_end && rev_ff == PBIL_REV_LAST) begin
            mode_ff <= PBIL_PRINT;  // see [R14]
          end
        end
        PBIL_PRINT: begin
          if (done_req) begin
            mode_ff <= PBIL_IDLE;
          end
        end
      endcase
    end
  end

  // first turn mark arms pass one, later ones step it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rev_ff <= '0;
    end else if (mode_ff != PBIL_LOAD) begin
      rev_ff <= '0;
    end else if (s_a && rev_ff != PBIL_REV_LAST) begin
      rev_ff <= rev_ff + 2'd1;      // see [R6]
    end
  end

  // ----------------------------------------------------------------
  // fetch and register load
  // ----------------------------------------------------------------
  logic ms_read_ff;   // main storage read request
  logic reg_ctl_ff;   // store fetched part at next location
  logic primed_ff;    // next part goes to X

  // band places sentinels one location early; primed part
  // sits five locations on, so parts arrive A then X
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ms_read_ff <= 1'b0;
    end else begin
      ms_read_ff <= (mode_ff == PBIL_LOAD) & s_b;  // see [R1] [R19]
    end
  end

  // register control holds until the part is stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_ctl_ff <= 1'b0;
    end else if (load_mark) begin
      reg_ctl_ff <= 1'b1;           // see [R2] [R8] [R11]
    end else if (s_loc) begin
      reg_ctl_ff <= 1'b0;
    end
  end

  // steering flop: only a primed part is preceded by it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      primed_ff <= 1'b0;
    end else if (mode_ff == PBIL_LOAD && s_f) begin
      primed_ff <= 1'b1;            // see [R3]
    end else if (s_loc && reg_ctl_ff) begin
      primed_ff <= 1'b0;
    end
  end

  logic [CHARS*4-1:0] reg_a_ff;   // unprimed, four bits a char
  logic [CHARS*3-1:0] reg_x_ff;   // primed two bits plus check

  // part is latched at the location after its sentinel
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_a_ff <= '0;
      reg_x_ff <= '0;
    end else if (s_loc && reg_ctl_ff) begin
      if (primed_ff) begin
        for (int c = 0; c < CHARS; c++) begin
          reg_x_ff[c*3 +: 3] <= {ms_check_i[c],
                                 ms_prime_i[c*2 +: 2]};  // see [R20]
        end
      end else begin
        reg_a_ff <= ms_word_i;      // see [R3] [R20]
      end
    end
  end

  // ----------------------------------------------------------------
  // buffer write
  // ----------------------------------------------------------------
  logic wr_ctl_ff;    // write control, blocks reading
  logic wr_ff;        // write alert for both tracks

  // one write per store mark; cleared as soon as done, though
  // reading stays blocked while loading; both flops self-clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ctl_ff <= 1'b0;
      wr_ff     <= 1'b0;
    end else begin
      wr_ctl_ff <= store_mark;      // see [R4] [R9] [R12]
      wr_ff     <= wr_ctl_ff & ~wr_ff; // see [R23]
    end
  end

  // words per pass follow from band sentinel layout
  logic [7:0] wr_cnt_ff;   // writes this load
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_cnt_ff <= '0;
    end else if (start_req) begin
      wr_cnt_ff <= '0;
    end else if (wr_ctl_ff && !wr_ff) begin
      wr_cnt_ff <= wr_cnt_ff + 8'd1; // see [R5] [R10] [R13]
    end
  end

  // seven heads fire together: four on A, three on X
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_write_o  <= 1'b0;
      head_en_o    <= '0;
      track_a_o    <= '0;
      track_x_o    <= '0;
      read_block_o <= 1'b0;
    end else begin
      buf_write_o  <= wr_ctl_ff & ~wr_ff;
      head_en_o    <= (wr_ctl_ff & ~wr_ff) ?
                      PBIL_HEADS_WRITE : 8'h00;  // see [R21]
      track_a_o    <= reg_a_ff;
      track_x_o    <= reg_x_ff;
      // reading stays blocked for whole load
      read_block_o <= (mode_ff == PBIL_LOAD) | wr_ctl_ff;
    end
  end

  // ----------------------------------------------------------------
  // quadrant counter, shared by writing and reading
  // ----------------------------------------------------------------
  logic [1:0] quad_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      quad_ff <= '0;
    end else if (mode_ff == PBIL_LOAD && s_wq) begin
      quad_ff <= quad_ff + 2'd1;    // see [R7]
    end else if (mode_ff == PBIL_PRINT && s_rq) begin
      quad_ff <= quad_ff + 2'd1;    // see [R15]
    end
  end

  // ----------------------------------------------------------------
  // readout: word counter and error window
  // ----------------------------------------------------------------
  logic [3:0] word_ff;   // 0 idle, 1..14 word in group
  logic       win_ff;    // error check window open
  logic       err_ff;    // print buffer error
  logic       clr_err;   // software clear

  // seed sets first stage; each location steps one word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word_ff <= '0;
    end else if (mode_ff != PBIL_PRINT) begin
      word_ff <= '0;
    end else if (s_k) begin
      word_ff <= 4'd1;              // see [R16]
    end else if (s_loc && word_ff != 4'd0) begin
      if (word_ff == PBIL_GROUP_WORDS) begin
        word_ff <= 4'd0;            // see [R17]
      end else begin
        word_ff <= word_ff + 4'd1;
      end
    end
  end

  // window closes with the group so idle reads never flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_ff <= 1'b0;
    end else if (mode_ff != PBIL_PRINT) begin
      win_ff <= 1'b0;
    end else if (s_y) begin
      win_ff <= 1'b1;               // see [R18]
    end else if (s_loc && word_ff == PBIL_GROUP_WORDS) begin
      win_ff <= 1'b0;
    end
  end

  // sticky error; a new error beats a software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_ff <= 1'b0;
    end else if (win_ff && cmp_active_i && cmp_error_i) begin
      err_ff <= 1'b1;               // see [R18]
    end else if (clr_err) begin
      err_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // hand over to print
  // ----------------------------------------------------------------
  logic end_evt;
  assign end_evt = (mode_ff == PBIL_LOAD) & s_end &
                   (rev_ff == PBIL_REV_LAST);

  // ending pulse clears instruction and sets print flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      print_start_pulse_o <= 1'b0;
      print_flag_o        <= 1'b0;
    end else begin
      print_start_pulse_o <= end_evt;   // see [R14]
      if (end_evt) begin
        print_flag_o <= 1'b1;
      end else if (done_req) begin
        print_flag_o <= 1'b0;
      end
    end
  end

  // registered copies of internal state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ms_read_o    <= 1'b0;
      quadrant_o   <= '0;
      buf_error_o  <= 1'b0;
      word_count_o <= '0;
    end else begin
      ms_read_o    <= ms_read_ff;
      quadrant_o   <= quad_ff;
      buf_error_o  <= err_ff;
      word_count_o <= word_ff;
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  logic req;        // new access, not yet acknowledged
  logic wr_lo;      // write touching byte lane 0
  assign req   = cyc_i & stb_i & ~ack_o;
  assign wr_lo = req & we_i & sel_i[0];

  // start only from idle; later writes are ignored
  assign start_req = wr_lo & (adr_i == PBIL_CTRL_ADR) &
                     dat_i[PBIL_CTRL_START_BIT] &
                     (mode_ff == PBIL_IDLE);
  assign clr_err   = wr_lo & (adr_i == PBIL_CTRL_ADR) &
                     dat_i[PBIL_CTRL_CLRERR_BIT];
  assign done_req  = wr_lo & (adr_i == PBIL_CTRL_ADR) &
                     dat_i[PBIL_CTRL_DONE_BIT];

  logic [31:0] nxt_dat;
  always_comb begin
    nxt_dat = '0;
    unique case (adr_i)
      PBIL_STATUS_ADR: begin
        nxt_dat[PBIL_ST_LOAD_BIT]  = (mode_ff == PBIL_LOAD);
        nxt_dat[PBIL_ST_PRINT_BIT] = (mode_ff == PBIL_PRINT);
        nxt_dat[PBIL_ST_ERR_BIT]   = err_ff;
        nxt_dat[PBIL_ST_REV_LSB +: 2]  = rev_ff;
        nxt_dat[PBIL_ST_QUAD_LSB +: 2] = quad_ff;
        nxt_dat[PBIL_ST_WORD_LSB +: 4] = word_ff;
        nxt_dat[PBIL_ST_WIN_BIT]   = win_ff;
      end
      PBIL_WRCNT_ADR: begin
        nxt_dat[7:0] = wr_cnt_ff;
      end
      default: begin
        nxt_dat = '0;   // control and unmapped read zero
      end
    endcase
  end

  // one wait state; ack drops the cycle after it rose
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= req;
      dat_o <= req ? nxt_dat : 32'h0000_0000;
    end
  end

endmodule

// ---- tb/pbil_loader_assertions.sv ----
// concurrent checks on the loader ports
module pbil_loader_checker
  import pbil_pkg::*;
#(
  parameter int CHARS = 10  // characters per word
) (
  // clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic [31:0] dat_o,
  // drum pins and comparator
  input wire logic [3:0]  phase_i,
  input wire logic [3:0]  band_ts_i,
  input wire logic        cmp_error_i,
  // loader outputs
  input wire logic        ms_read_o,
  input wire logic        buf_write_o,
  input wire logic [7:0]  head_en_o,
  input wire logic [1:0]  quadrant_o,
  input wire logic        read_block_o,
  input wire logic        print_start_pulse_o,
  input wire logic        print_flag_o,
  input wire logic        buf_error_o,
  input wire logic [3:0]  word_count_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_ack_after_req : assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing after request");
  a_ack_one_cycle : assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_dat_quiet : assert property (!ack_o |-> dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  // pins are still held when the read pulse leaves
  a_read_on_fetch : assert property (
    ms_read_o |-> phase_i == PBIL_T8 && band_ts_i[1] && !$past(ms_read_o))
    else $error("storage read without fetch sentinel");
  a_store_phase : assert property (
    buf_write_o |-> phase_i == PBIL_T3 && read_block_o)
    else $error("buffer write without store sentinel");
  a_write_clears : assert property (buf_write_o |=> !buf_write_o)
    else $error("write control not cleared");
  a_heads_seven : assert property (
    head_en_o == (buf_write_o ? PBIL_HEADS_WRITE : 8'h00))
    else $error("head enables wrong");
  a_quad_step : assert property (
    !$stable(quadrant_o) && !$past(rst_i)
      |-> quadrant_o == $past(quadrant_o) + 2'h1)
    else $error("quadrant counter jumped");
  a_end_pulse : assert property (
    print_start_pulse_o |-> phase_i == PBIL_T2
      ##1 (print_flag_o && !print_start_pulse_o))
    else $error("ending pulse wrong");
  a_word_range : assert property (
    word_count_o <= PBIL_GROUP_WORDS)
    else $error("word counter beyond fourteen");
  a_err_cause : assert property (
    $rose(buf_error_o) |-> $past(cmp_error_i) || $past(cmp_error_i, 2)
      || $past(cmp_error_i, 3))
    else $error("buffer error without comparator error");
endmodule

bind pbil_loader pbil_loader_checker #(.CHARS(CHARS)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o), .dat_o(dat_o), .phase_i(phase_i),
  .band_ts_i(band_ts_i), .cmp_error_i(cmp_error_i),
  .ms_read_o(ms_read_o), .buf_write_o(buf_write_o),
  .head_en_o(head_en_o), .quadrant_o(quadrant_o),
  .read_block_o(read_block_o),
  .print_start_pulse_o(print_start_pulse_o),
  .print_flag_o(print_flag_o), .buf_error_o(buf_error_o),
  .word_count_o(word_count_o));

// ---- tb/pbil_drum_model.sv ----
// drum timing band and main storage model facing the loader
module pbil_drum_model
  import pbil_pkg::*;
#(
  parameter int CHARS = 10  // characters per word
) (
  // clock
  input  wire logic          clk_i,
  // drum pins
  output logic               phase_stb_o,
  output logic [3:0]         phase_o,
  output logic [3:0]         band_ts_o,
  // main storage word part
  output logic [CHARS*4-1:0] ms_word_o,
  output logic [CHARS*2-1:0] ms_prime_o,
  output logic [CHARS-1:0]   ms_check_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    phase_stb_o = 1'b0;
    phase_o     = 4'h1;  // t1 carries no sentinel
    band_ts_o   = 4'h0;
    ms_word_o   = '0;
    ms_prime_o  = '0;
    ms_check_o  = '0;
  end

  // pins settle three clocks before the strobe and hold after it
  task automatic sentinel(input logic [3:0] ph, input logic [3:0] ts);
    phase_o   <= ph;
    band_ts_o <= ts;
    repeat (3) @(posedge clk_i);
    phase_stb_o <= 1'b1;
    repeat (6) @(posedge clk_i);
    phase_stb_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    phase_o   <= 4'h1;
    band_ts_o <= ~ts;  // released lines never repeat the last value
    @(posedge clk_i);
  endtask

  // one word part offered at its location, inverted once passed
  task automatic part(input logic [CHARS*4-1:0] w,
                      input logic [CHARS*2-1:0] p,
                      input logic [CHARS-1:0]   c);
    ms_word_o  <= w;
    ms_prime_o <= p;
    ms_check_o <= c;
    sentinel(PBIL_T0, 4'h0);
    ms_word_o  <= ~w;
    ms_prime_o <= ~p;
    ms_check_o <= ~c;
  endtask
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the print buffer interlace loader
module testbench;
  import pbil_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CHARS = 10;

  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, cmp_active_i, cmp_error_i;
  logic [3:0] adr_i, sel_i, phase_i, band_ts_i, word_count_o;
  logic [31:0] dat_i, dat_o, d;
  logic phase_stb_i, ms_read_o, buf_write_o, read_block_o;
  logic print_start_pulse_o, print_flag_o, buf_error_o;
  logic [CHARS*4-1:0] ms_word_i, track_a_o;
  logic [CHARS*2-1:0] ms_prime_i;
  logic [CHARS-1:0] ms_check_i;
  logic [CHARS*3-1:0] track_x_o;
  logic [7:0] head_en_o;
  logic [1:0] quadrant_o;
  int failures, comparisons, writes, reads, starts;

  pbil_loader #(.CHARS(CHARS)) u_dut (.*);
  pbil_drum_model #(.CHARS(CHARS)) drum (.clk_i(clk_i),
    .phase_stb_o(phase_stb_i), .phase_o(phase_i), .band_ts_o(band_ts_i),
    .ms_word_o(ms_word_i), .ms_prime_o(ms_prime_i),
    .ms_check_o(ms_check_i));

  always #25 clk_i = ~clk_i;

  // pulse tallies kept apart from the design
  always @(posedge clk_i) begin
    writes += (buf_write_o === 1'b1);
    reads  += (ms_read_o === 1'b1);
    starts += (print_start_pulse_o === 1'b1);
  end

  task automatic final_report();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // classic single cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    sel_i <= 4'h1;
    adr_i <= a;
    dat_i <= wd;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (ack_o !== 1'b1) begin
      failures++;
      $display("mismatch at %0t: bus timeout", $time);
      final_report();
    end else begin
      @(posedge clk_i);
    end
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0000_0000, v);
    check(40'(v), 40'(exp));
  endtask

  // one loading revolution with wrong-pass store sentinel mixed in
  task automatic pass(input int rev, input logic [3:0] lts, sts, wts,
                      input logic [3:0] nib, input logic [1:0] pb,
                      input logic cb);
    int w0, r0;
    w0 = writes;
    r0 = reads;
    drum.sentinel(PBIL_T8, 4'h2);
    drum.sentinel(PBIL_T10, lts);
    drum.part({CHARS{nib}}, {CHARS{~pb}}, {CHARS{~cb}});
    drum.sentinel(PBIL_T8, 4'h2);
    drum.sentinel(PBIL_T10, 4'h8);
    drum.sentinel(PBIL_T10, lts);
    drum.part({CHARS{~nib}}, {CHARS{pb}}, {CHARS{cb}});
    check(40'(reads - r0), 40'h2);
    check(40'(track_a_o), {CHARS{nib}});
    check(40'(track_x_o), 40'({CHARS{cb, pb}}));
    repeat (3) drum.sentinel(PBIL_T3, sts);
    drum.sentinel(PBIL_T3, wts);
    check(40'(writes - w0), 40'h3);
    rd_chk(PBIL_WRCNT_ADR, 32'(3 * rev));
    drum.sentinel(PBIL_T11, 4'h4);
    check(40'(quadrant_o), 40'(rev));
  endtask

  task automatic err_burst();
    cmp_active_i <= 1'b1;
    cmp_error_i  <= 1'b1;
    repeat (4) @(posedge clk_i);
    cmp_active_i <= 1'b0;
    cmp_error_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  // readout: quadrant, group seed, error window, word count
  task automatic print_phase();
    int r0;
    r0 = reads;
    drum.sentinel(PBIL_T8, 4'h2);
    check(40'(reads - r0), 40'h0);
    drum.sentinel(PBIL_T4, 4'h1);
    drum.sentinel(PBIL_T4, 4'h2);
    drum.sentinel(PBIL_T4, 4'h4);
    check(40'(quadrant_o), 40'h2);
    check(40'(read_block_o), 40'h0);
    err_burst();
    check(40'(buf_error_o), 40'h0);
    drum.sentinel(PBIL_T7, 4'h1);
    drum.sentinel(PBIL_T5, 4'h2);
    check(40'(word_count_o), 40'h1);
    err_burst();
    check(40'(buf_error_o), 40'h1);
    bus(1'b1, PBIL_CTRL_ADR, 32'h0000_0002, d);
    check(40'(buf_error_o), 40'h0);
    repeat (13) drum.sentinel(PBIL_T0, 4'h0);
    check(40'(word_count_o), 40'he);
    drum.sentinel(PBIL_T0, 4'h0);
    check(40'(word_count_o), 40'h0);
    bus(1'b1, PBIL_CTRL_ADR, 32'h0000_0004, d);
    check(40'(print_flag_o), 40'h0);
  endtask

  initial begin
    {clk_i, cyc_i, stb_i, we_i, cmp_active_i, cmp_error_i} = '0;
    rst_i = 1'b1;
    adr_i = 4'h0;
    sel_i = 4'h1;
    dat_i = 32'h0000_0000;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk(PBIL_STATUS_ADR, 32'h0000_0000);
    rd_chk(4'hc, 32'h0000_0000);
    bus(1'b1, PBIL_CTRL_ADR, 32'h0000_0001, d);
    drum.sentinel(PBIL_T9, 4'h1);
    rd_chk(PBIL_STATUS_ADR, 32'h0000_0011);
    pass(1, 4'h1, 4'h1, 4'h2, 4'h5, 2'b10, 1'b1);
    drum.sentinel(PBIL_T9, 4'h1);
    pass(2, 4'h2, 4'h2, 4'h8, 4'ha, 2'b01, 1'b0);
    drum.sentinel(PBIL_T9, 4'h1);
    pass(3, 4'h4, 4'h8, 4'h1, 4'h3, 2'b11, 1'b1);
    drum.sentinel(PBIL_T2, 4'h1);
    check(40'(starts), 40'h1);
    check(40'(print_flag_o), 40'h1);
    bus(1'b0, PBIL_STATUS_ADR, 32'h0000_0000, d);
    check(40'(d[1:0]), 40'h2);
    print_phase();
    final_report();
  end
endmodule
